//--- design/gos_output_select.sv
// general output signal select: three pins, per-pin code and inversion,
// one shared crystal clock divider, AXI4-Lite register slave, one level interrupt
// assumes radio core status inputs arrive on aclk; the pin pads resolve oe
// Contract
// [R01] code 0x02: pin active while fifo level at or above threshold
// [R02] code 0x03: set on fifo full, cleared once level below threshold
// [R03] code 0x05: set on underflow, held until fifo flush
// [R04] code 0x06: set after sync word, cleared at packet end or underflow
// [R05] code 0x0a: pll lock detector; controller treats rising edge as lock
// [R06] code 0x0b: serial clock; data sampled on its rising edge, uninverted
// [R07] code 0x0c sync serial data, code 0x0d async serial data
// [R08] code 0x1b: amplifier power-down flag, same level in sleep and transmit
// [R09] code 0x2f: static zero, or one when inverted
// [R10] controller selects a divided clock on at most one pin
// [R11] codes 0x30-0x3f divide crystal clock 1..192; pin 0 defaults to 192
// [R12] controller avoids divided clocks while transmitting
// [R13] codes below 0x20: pins hardwired during sleep until chip ready low falls
// [R14] codes 0x20 and up keep driving the selection in sleep
// [R15] code 0x2e: pin high impedance in every state
// [R16] controller never programs reserved test codes
// [R17] each pin has its own code and inversion, inversion applied to selection
module gos_output_select
  import gos_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gos_radio_type radio,
  output gos_pins_type pins,
  output logic irq
);

  gos_pin_cfg_type cfg_q [GOS_PINS];
  logic [GOS_FIFO_W-1:0] thr_q;
  logic [GOS_IRQ_W-1:0] irq_stat_q;
  logic [GOS_IRQ_W-1:0] irq_mask_q;

  // status flags
  logic thr_flag;
  logic full_q;
  logic underflow_q;
  logic packet_q;
  logic lock_prev_q;

  assign thr_flag = radio.fifo_level >= thr_q; // R01

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_q <= 1'b0;
      underflow_q <= 1'b0;
      packet_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      if (radio.fifo_full) begin
        full_q <= 1'b1; // R02
      end else if (!thr_flag) begin
        full_q <= 1'b0; // R02
      end
      if (radio.underflow) begin
        underflow_q <= 1'b1; // R03
      end else if (radio.flush) begin
        underflow_q <= 1'b0; // R03
      end
      // underflow and packet end take priority over a late sync
      if (radio.packet_end || radio.underflow) begin
        packet_q <= 1'b0; // R04
      end else if (radio.sync_sent) begin
        packet_q <= 1'b1; // R04
      end
      lock_prev_q <= radio.pll_lock;
    end
  end

  // shared clock divider
  // one divider only: a second clock selection would be a controller fault
  logic [GOS_PINS-1:0] clk_sel;
  logic [3:0] div_idx;
  logic clk_any;
  logic [GOS_DIV_W-1:0] div_cnt_q;
  logic [3:0] div_idx_q;
  logic div_out;
  logic [GOS_DIV_W-1:0] div_last;

  for (genvar p = 0; p < GOS_PINS; p++) begin : g_clk_sel
    assign clk_sel[p] = cfg_q[p].code >= GOS_SEL_CLK_BASE;
  end

  // lowest pin wins if software breaks the one-clock limit
  assign div_idx = clk_sel[0] ? cfg_q[0].code[3:0] :
                   clk_sel[1] ? cfg_q[1].code[3:0] : cfg_q[2].code[3:0]; // R10
  assign clk_any = |clk_sel;
  assign div_last = GOS_DIV_PERIOD[div_idx_q] - 9'h001;
  assign div_out = div_cnt_q < (GOS_DIV_PERIOD[div_idx_q] >> 1); // R11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= '0;
      div_idx_q <= GOS_RST_CODE0[3:0];
    end else if (!clk_any || div_idx != div_idx_q) begin
      div_cnt_q <= '0;
      div_idx_q <= div_idx;
    end else if (div_cnt_q >= div_last) begin
      div_cnt_q <= '0; // R11
    end else begin
      div_cnt_q <= div_cnt_q + 9'h001;
    end
  end

  // per pin selection
  logic [GOS_PINS-1:0] sel_level;
  logic [GOS_PINS-1:0] pin_d;
  logic [GOS_PINS-1:0] oe_d;
  logic [GOS_PINS-1:0] sleep_hw;
  logic [GOS_PINS-1:0] pin_q;
  logic [GOS_PINS-1:0] oe_q;

  for (genvar p = 0; p < GOS_PINS; p++) begin : g_pin
    logic [5:0] code;
    logic inv;
    logic hw_level;
    assign code = cfg_q[p].code;
    assign inv = cfg_q[p].invert;
    assign sel_level[p] =
      (code == GOS_SEL_FIFO_THR) ? thr_flag : // R01
      (code == GOS_SEL_FIFO_FULL) ? full_q : // R02
      (code == GOS_SEL_UNDERFLOW) ? underflow_q : // R03
      (code == GOS_SEL_PACKET) ? packet_q : // R04
      (code == GOS_SEL_PLL_LOCK) ? radio.pll_lock : // R05
      (code == GOS_SEL_SER_CLK) ? radio.serial_clk : // R06
      (code == GOS_SEL_SYNC_DATA) ? radio.sync_data : // R07
      (code == GOS_SEL_ASYNC_DATA) ? radio.async_data : // R07
      (code == GOS_SEL_AMP_PD) ? radio.amp_powerdown_flag : // R08
      (code == GOS_SEL_CHIP_READY) ? radio.chip_ready_low :
      (code == GOS_SEL_XOSC_STABLE) ? radio.xosc_stable :
      (code == GOS_SEL_STATIC) ? 1'b0 : // R09
      clk_sel[p] ? (div_out & div_idx == code[3:0]) : // R11
      1'b0; // reserved codes select low, so the pin is driven high when inverted
    // sleep hardwire: pin 1 idles at the complement
    assign hw_level = (p == 1) ? ~inv : inv; // R13
    assign sleep_hw[p] = code < GOS_SEL_SLEEP_LIMIT && radio.chip_ready_low; // R13 R14
    assign pin_d[p] = sleep_hw[p] ? hw_level : (sel_level[p] ^ inv); // R17 R09
    assign oe_d[p] = code != GOS_SEL_HIGH_Z; // R15
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '0;
      oe_q <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign pins.out = pin_q;
  assign pins.oe = oe_q;

  // interrupt events
  logic [GOS_IRQ_W-1:0] irq_event;
  assign irq_event[GOS_IRQ_LOCK] = radio.pll_lock & ~lock_prev_q; // R05
  assign irq_event[GOS_IRQ_UNDERFLOW] = radio.underflow;
  assign irq_event[GOS_IRQ_SYNC] = radio.sync_sent;
  assign irq_event[GOS_IRQ_PKT_END] = radio.packet_end;
  assign irq = |(irq_stat_q & irq_mask_q);

  // AXI4-Lite write
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] wr_mask;
  logic [31:0] wr_merge_cfg [GOS_PINS];
  logic wr_cfg_hit [GOS_PINS];
  logic wr_thr;
  logic wr_stat;
  logic wr_msk;
  logic wr_ok;
  logic [GOS_IRQ_W-1:0] stat_clear;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = (aw_got_q || aw_take) && (w_got_q || w_take);
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  for (genvar p = 0; p < GOS_PINS; p++) begin : g_wr_cfg
    assign wr_cfg_hit[p] = wr_do && wr_addr == GOS_ADDR_PIN_CFG0 + 8'(4 * p);
    assign wr_merge_cfg[p] = (wr_data & wr_mask) | ({25'h0, cfg_q[p]} & ~wr_mask);
  end

  assign wr_thr = wr_do && wr_addr == GOS_ADDR_FIFO_THR && wr_strb[0];
  assign wr_stat = wr_do && wr_addr == GOS_ADDR_IRQ_STAT && wr_strb[0];
  assign wr_msk = wr_do && wr_addr == GOS_ADDR_IRQ_MASK && wr_strb[0];
  assign wr_ok = wr_cfg_hit[0] || wr_cfg_hit[1] || wr_cfg_hit[2] ||
                 wr_addr == GOS_ADDR_FIFO_THR || wr_addr == GOS_ADDR_STATE ||
                 wr_addr == GOS_ADDR_IRQ_STAT || wr_addr == GOS_ADDR_IRQ_MASK;
  assign stat_clear = wr_stat ? wr_data[GOS_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= GOS_RESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? GOS_RESP_OKAY : GOS_RESP_SLVERR;
      end else begin
        aw_got_q <= aw_got_q | aw_take;
        w_got_q <= w_got_q | w_take;
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q[0] <= '{invert: 1'b0, code: GOS_RST_CODE0}; // R11
      cfg_q[1] <= '{invert: 1'b0, code: GOS_RST_CODE1};
      cfg_q[2] <= '{invert: 1'b0, code: GOS_RST_CODE2};
      thr_q <= GOS_RST_FIFO_THR;
      irq_mask_q <= GOS_RST_IRQ_MASK;
      irq_stat_q <= '0;
    end else begin
      for (int p = 0; p < GOS_PINS; p++) begin
        if (wr_cfg_hit[p]) begin
          cfg_q[p] <= wr_merge_cfg[p][6:0]; // R17
        end
      end
      if (wr_thr) begin
        thr_q <= wr_data[GOS_FIFO_W-1:0];
      end
      if (wr_msk) begin
        irq_mask_q <= wr_data[GOS_IRQ_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~stat_clear) | irq_event;
    end
  end

  // AXI4-Lite read
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] state_word;

  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign state_word = {16'h0, 1'b0, radio.fifo_level, 1'b0, radio.pll_lock,
                       packet_q, underflow_q, full_q, thr_flag, clk_any, 1'b0};
  assign rd_ok = s_axi_araddr == GOS_ADDR_PIN_CFG0 || s_axi_araddr == GOS_ADDR_PIN_CFG1 ||
                 s_axi_araddr == GOS_ADDR_PIN_CFG2 || s_axi_araddr == GOS_ADDR_FIFO_THR ||
                 s_axi_araddr == GOS_ADDR_STATE || s_axi_araddr == GOS_ADDR_IRQ_STAT ||
                 s_axi_araddr == GOS_ADDR_IRQ_MASK;
  assign rd_word =
    (s_axi_araddr == GOS_ADDR_PIN_CFG0) ? {25'h0, cfg_q[0]} :
    (s_axi_araddr == GOS_ADDR_PIN_CFG1) ? {25'h0, cfg_q[1]} :
    (s_axi_araddr == GOS_ADDR_PIN_CFG2) ? {25'h0, cfg_q[2]} :
    (s_axi_araddr == GOS_ADDR_FIFO_THR) ? {25'h0, thr_q} :
    (s_axi_araddr == GOS_ADDR_STATE) ? state_word :
    (s_axi_araddr == GOS_ADDR_IRQ_STAT) ? {28'h0, irq_stat_q} :
    (s_axi_araddr == GOS_ADDR_IRQ_MASK) ? {28'h0, irq_mask_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= GOS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? GOS_RESP_OKAY : GOS_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

//--- pkg/gos_pkg.sv
// constants, carriers and register map of the general output signal select block
// assumes a single 50 MHz clock and an AXI4-Lite register master
package gos_pkg;

  localparam int GOS_PINS = 3;
  localparam int GOS_FIFO_W = 7;

  // select codes
  localparam logic [5:0] GOS_SEL_FIFO_THR = 6'h02;
  localparam logic [5:0] GOS_SEL_FIFO_FULL = 6'h03;
  localparam logic [5:0] GOS_SEL_UNDERFLOW = 6'h05;
  localparam logic [5:0] GOS_SEL_PACKET = 6'h06;
  localparam logic [5:0] GOS_SEL_PLL_LOCK = 6'h0a;
  localparam logic [5:0] GOS_SEL_SER_CLK = 6'h0b;
  localparam logic [5:0] GOS_SEL_SYNC_DATA = 6'h0c;
  localparam logic [5:0] GOS_SEL_ASYNC_DATA = 6'h0d;
  localparam logic [5:0] GOS_SEL_AMP_PD = 6'h1b;
  localparam logic [5:0] GOS_SEL_SLEEP_LIMIT = 6'h20;
  localparam logic [5:0] GOS_SEL_CHIP_READY = 6'h29;
  localparam logic [5:0] GOS_SEL_XOSC_STABLE = 6'h2b;
  localparam logic [5:0] GOS_SEL_HIGH_Z = 6'h2e;
  localparam logic [5:0] GOS_SEL_STATIC = 6'h2f;
  localparam logic [5:0] GOS_SEL_CLK_BASE = 6'h30;

  // divided clock periods in aclk cycles, one crystal cycle = two aclk cycles
  localparam int GOS_DIV_W = 9;
  localparam logic [8:0] GOS_DIV_PERIOD [16] = '{
    9'h002, 9'h003, 9'h004, 9'h006, 9'h008, 9'h00c, 9'h010, 9'h018,
    9'h020, 9'h030, 9'h040, 9'h060, 9'h080, 9'h0c0, 9'h100, 9'h180};

  // register byte addresses
  localparam logic [7:0] GOS_ADDR_PIN_CFG0 = 8'h00;
  localparam logic [7:0] GOS_ADDR_PIN_CFG1 = 8'h04;
  localparam logic [7:0] GOS_ADDR_PIN_CFG2 = 8'h08;
  localparam logic [7:0] GOS_ADDR_FIFO_THR = 8'h0c;
  localparam logic [7:0] GOS_ADDR_STATE = 8'h10;
  localparam logic [7:0] GOS_ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] GOS_ADDR_IRQ_MASK = 8'h18;

  // field positions in a pin config word
  localparam int GOS_CFG_CODE_LSB = 0;
  localparam int GOS_CFG_INV_BIT = 6;

  // reset values
  localparam logic [5:0] GOS_RST_CODE0 = 6'h3f;
  localparam logic [5:0] GOS_RST_CODE1 = 6'h2e;
  localparam logic [5:0] GOS_RST_CODE2 = 6'h2e;
  localparam logic [6:0] GOS_RST_FIFO_THR = 7'h20;
  localparam logic [3:0] GOS_RST_IRQ_MASK = 4'h0;

  // interrupt event bits
  localparam int GOS_IRQ_W = 4;
  localparam int GOS_IRQ_LOCK = 0;
  localparam int GOS_IRQ_UNDERFLOW = 1;
  localparam int GOS_IRQ_SYNC = 2;
  localparam int GOS_IRQ_PKT_END = 3;

  localparam logic [1:0] GOS_RESP_OKAY = 2'b00;
  localparam logic [1:0] GOS_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic invert;
    logic [5:0] code;
  } gos_pin_cfg_type;

  // radio core signals, all on aclk
  typedef struct packed {
    logic [GOS_FIFO_W-1:0] fifo_level;
    logic fifo_full;
    logic underflow;
    logic flush;
    logic sync_sent;
    logic packet_end;
    logic pll_lock;
    logic serial_clk;
    logic sync_data;
    logic async_data;
    logic amp_powerdown_flag;
    logic chip_ready_low;
    logic xosc_stable;
  } gos_radio_type;

  typedef struct packed {
    logic [GOS_PINS-1:0] out;
    logic [GOS_PINS-1:0] oe;
  } gos_pins_type;

endpackage

//--- testbench/gos_mcu.sv
// controller model: samples the three output pins
// assumes pins come from gos_output_select on aclk
module gos_mcu
  import gos_pkg::*;
(
  input wire logic aclk,
  input wire gos_pins_type pins,
  input wire logic clr,
  output logic [2:0] level,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  // released pins read high through a pull-up
  assign level = pins.out | ~pins.oe;
  // a rising edge counts as one event, like a lock interrupt
  always_ff @(posedge aclk) begin
    prev_q <= level[0];
    if (clr) rises <= 0;
    else if (level[0] && !prev_q) rises <= rises + 1;
  end
endmodule

//--- testbench/gos_output_select_assertions.sv
// port checker for the output select block
// assumes all writes use full strobes
module gos_chk
  import gos_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gos_radio_type radio,
  input wire gos_pins_type pins,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] c_q;
  logic [1:0] age_q;
  wire aw_ok = s_axi_awvalid && s_axi_awready;
  wire w_ok = s_axi_wvalid && s_axi_wready;
  wire wr0 = aw_ok && w_ok && s_axi_awaddr == GOS_ADDR_PIN_CFG0;
  // shadow of pin 0 config; age gives the pin time to follow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= {1'b0, GOS_RST_CODE0};
      age_q <= 2'h0;
    end else if (wr0) begin
      c_q <= s_axi_wdata[6:0];
      age_q <= 2'h0;
    end else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  wire set = age_q > 2'h1;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_answer: assert property (aw_ok && w_ok |=> s_axi_bvalid)
    else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_high_z: assert property (set && c_q[5:0] == 6'h2e |-> !pins.oe[0])
    else $error("pin driven in high impedance code");
  a_static_level: assert property (set && c_q[5:0] == 6'h2f |-> pins.oe[0]
    && pins.out[0] == c_q[6]) else $error("static level wrong");
  a_lock_follow: assert property (set && c_q[5:0] == 6'h0a
    && !$past(radio.chip_ready_low) |-> pins.out[0] == ($past(radio.pll_lock) ^ c_q[6]))
    else $error("lock pin wrong");
  a_sleep_wired: assert property (set && c_q[5:0] < 6'h20
    && $past(radio.chip_ready_low) |-> pins.out[0] == c_q[6]) else $error("sleep level wrong");
  cover property (set && c_q[5:0] == 6'h0a);
  cover property (irq);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind gos_output_select gos_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .radio, .pins, .irq);

//--- testbench/testbench.sv
// bench for the output select block
// assumes the controller model and bound checker
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gos_pkg::*;
  logic aclk = 0, aresetn = 0, clr = 0, irq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  gos_radio_type radio = '0;
  gos_pins_type pins;
  logic [2:0] level;
  int rises, err_total = 0, n_tests = 0;
  always #10 aclk = ~aclk;
  gos_output_select dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .radio, .pins, .irq);
  gos_mcu mcu_u (.aclk, .pins, .clr, .level, .rises);
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task hang;
    err_total++;
    $display("[FAIL] %0t bus timeout", $time);
    results;
  endtask
  task go(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ready is combinational, so it is judged at the falling edge before use
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      if (bh) break;
    end
    s_axi_bready <= 0;
    if (n == 50) hang;
  endtask
  task rd_reg(input logic [7:0] a);
    int n;
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 0;
      if (rh) break;
    end
    s_axi_rready <= 0;
    if (n == 50) hang;
  endtask
  task pulse(input int b);
    @(posedge aclk);
    radio[b] <= 1;
    @(posedge aclk);
    radio[b] <= 0;
    go(2);
  endtask
  task t_defaults;
    rd_reg(GOS_ADDR_PIN_CFG0);
    `CHK(rd[6:0], 7'h3f)
    go(0);
    `CHK(pins.oe, 3'b001)
    rd_reg(8'h40);
    `CHK(rsp, GOS_RESP_SLVERR)
    `CHK(rd, 32'h0)
    wr(8'h40, 32'h1);
    `CHK(rsp, GOS_RESP_SLVERR)
    $display("defaults done");
  endtask
  task t_clock;
    static logic [5:0] c[3] = '{6'h30, 6'h31, 6'h3f};
    static int p[3] = '{2, 3, 384};
    // one clock pin only, radio idle, legal codes
    for (int i = 0; i < 3; i++) begin
      wr(GOS_ADDR_PIN_CFG0, {26'h0, c[i]});
      repeat (4) @(posedge aclk);
      clr <= 1;
      @(posedge aclk);
      clr <= 0;
      go(2 * p[i]);
      `CHK(rises, 2)
    end
    $display("clock done");
  endtask
  task t_fifo;
    wr(GOS_ADDR_PIN_CFG1, 32'h02);
    wr(GOS_ADDR_PIN_CFG2, 32'h03);
    wr(GOS_ADDR_FIFO_THR, 32'h10);
    @(posedge aclk);
    radio.fifo_level <= 7'h10;
    go(3);
    `CHK(pins.out[2:1], 2'b01)
    @(posedge aclk);
    radio.fifo_full <= 1;
    go(3);
    `CHK(pins.out[2], 1'b1)
    @(posedge aclk);
    radio.fifo_full <= 0;
    go(3);
    `CHK(pins.out[2], 1'b1)
    @(posedge aclk);
    radio.fifo_level <= 7'h0f;
    go(3);
    `CHK(pins.out[2:1], 2'b00)
    $display("fifo done");
  endtask
  task t_events;
    wr(GOS_ADDR_PIN_CFG0, 32'h05);
    wr(GOS_ADDR_PIN_CFG2, 32'h06);
    wr(GOS_ADDR_IRQ_MASK, 32'h2);
    pulse(8);
    `CHK({pins.out[2], pins.out[0], irq}, 3'b100)
    pulse(10);
    `CHK({pins.out[2], pins.out[0], irq}, 3'b011)
    rd_reg(GOS_ADDR_IRQ_STAT);
    `CHK(rd[3:0], 4'h6)
    wr(GOS_ADDR_IRQ_STAT, 32'h2);
    go(2);
    `CHK({pins.out[0], irq}, 2'b10)
    pulse(9);
    `CHK(pins.out[0], 1'b0)
    pulse(8);
    pulse(7);
    `CHK(pins.out[2], 1'b0)
    wr(GOS_ADDR_IRQ_MASK, 32'h0);
    pulse(10);
    `CHK(irq, 1'b0)
    $display("events done");
  endtask
  task t_direct;
    static logic [5:0] c[7] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h1b, 6'h29, 6'h2b};
    static int b[7] = '{6, 5, 4, 3, 2, 1, 0};
    // codes 0x29 and 0x2b ignore sleep, so raising their inputs is harmless here
    for (int i = 0; i < 14; i++)
      for (int v = 0; v < 2; v++) begin
        wr(GOS_ADDR_PIN_CFG0, {25'h0, i[0], c[i / 2]});
        @(posedge aclk);
        radio[b[i / 2]] <= v[0];
        go(2);
        `CHK(pins.out[0], v[0] ^ i[0])
      end
    $display("direct done");
  endtask
  task t_sleep;
    wr(GOS_ADDR_PIN_CFG0, 32'h4c);
    wr(GOS_ADDR_PIN_CFG1, 32'h0a);
    wr(GOS_ADDR_PIN_CFG2, 32'h29);
    @(posedge aclk);
    radio.chip_ready_low <= 1;
    go(2);
    `CHK(pins.out, 3'b111)
    @(posedge aclk);
    radio.chip_ready_low <= 0;
    go(2);
    `CHK(pins.out, 3'b010)
    wr(GOS_ADDR_PIN_CFG0, 32'h6f);
    go(2);
    `CHK(pins.out[0], 1'b1)
    wr(GOS_ADDR_PIN_CFG0, 32'h2e);
    go(2);
    `CHK({pins.oe[0], level[0]}, 2'b01)
    wr(GOS_ADDR_PIN_CFG2, 32'h6f);
    go(2);
    `CHK(pins.out[2], 1'b1)
    wr(GOS_ADDR_PIN_CFG2, 32'h2f);
    go(2);
    `CHK(pins.out[2], 1'b0)
    $display("sleep done");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_defaults;
    t_clock;
    t_fifo;
    t_events;
    t_direct;
    t_sleep;
    results;
  end
endmodule
